// ### design/bsc_pkg.sv
package bsc_pkg;

  // chain length and positions (order 1 leaves on the test data output first)
  localparam int CELLS = 174;
  localparam int POS_COUNT_WRAP = 1;
  localparam int POS_DATA0_IN = 93;
  localparam int POS_DATA0_OUT = 94;
  localparam int POS_CHIP_RESET = 95;
  localparam int POS_EXT_REQ = 96;
  localparam int POS_MEM_FAULT = 97;
  localparam int POS_XFER_DONE = 98;
  localparam int POS_GROUP_FLOAT = 99;
  localparam int POS_GRANT = 100;
  localparam int POS_ERROR = 101;
  localparam int POS_BUS_HOLD = 102;
  localparam int POS_RW = 104;
  localparam int POS_STROBE = 105;
  localparam int POS_DONE0_DIR = 134;
  localparam int POS_DONE0_IN = 137;
  localparam int POS_DONE0_OUT = 138;
  localparam int POS_DONE1_DIR = 141;
  localparam int POS_DONE1_IN = 143;
  localparam int POS_DONE1_OUT = 144;
  localparam int POS_CLOCK_GATE = 174;

  // low data bits 5..0 sit as in/out pairs in one unbroken run
  localparam int DATA_LOW_BITS = 6;
  localparam int PAD_INS = 6;

  // test clock period in the bench, for reference
  localparam int TCK_PERIOD_NS = 160;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCK_CLKS = TCK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [15:0] {
    TAP_RESET   = 16'h0001,
    TAP_IDLE    = 16'h0002,
    TAP_SEL_DR  = 16'h0004,
    TAP_CAP_DR  = 16'h0008,
    TAP_SH_DR   = 16'h0010,
    TAP_EX1_DR  = 16'h0020,
    TAP_PA_DR   = 16'h0040,
    TAP_EX2_DR  = 16'h0080,
    TAP_UPD_DR  = 16'h0100,
    TAP_SEL_IR  = 16'h0200,
    TAP_CAP_IR  = 16'h0400,
    TAP_SH_IR   = 16'h0800,
    TAP_EX1_IR  = 16'h1000,
    TAP_PA_IR   = 16'h2000,
    TAP_EX2_IR  = 16'h4000,
    TAP_UPD_IR  = 16'h8000
  } bsc_tap_e;

endpackage : bsc_pkg

// ### design/bsc_sync.sv
`timescale 1ns/100ps
module bsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic clear,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge clk or posedge clear) begin
    if (clear) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : bsc_sync

// ### design/bsc_chain.sv
`timescale 1ns/100ps
// How it works
// - cell 99 at 1 floats address-group outputs; at 0 drives them
// - cell 134 steers done0 pin: 1 input, 0 output; cells 137/138
// - cell 141 steers done1 pin: 1 input, 0 output; cells 143/144
// - direction and float cells live only in the chain, no pad
// - page hit, selects, grant, wrap, error outputs never float
// - no cells for clock outputs, oscillator output or test pins
// - data bits as input then output cell, descending; bit 0 at 93/94
// - inputs: chip reset 95, bus request 96, fault 97, done 98
// - outputs: grant 100, error 101, hold 102, rw 104, strobe 105
// - wrap cell shifts out first; clock-gate cell 174 last
// - test reset clears scan logic asynchronously; held low if unused
module bsc_chain
  import bsc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // test port pins
  input wire logic test_clk,
  input wire logic test_mode_sel,
  input wire logic test_data_in,
  input wire logic test_rst_n,
  output logic test_data_out,
  output logic test_data_out_oe,
  // pad levels captured by the chain, order k at bit k-1
  input wire logic [bsc_pkg::CELLS-1:0] pad_capture,
  // named pads read by capture
  input wire logic chip_reset_n,
  input wire logic ext_master_req,
  input wire logic mem_fault_in_n,
  input wire logic xfer_done_n,
  input wire logic dma_done0_n_i,
  input wire logic dma_done1_n_i,
  // core side, same clock
  input wire logic scan_apply,
  input wire logic core_group_oe,
  input wire logic core_grant_n,
  input wire logic core_error_n,
  input wire logic core_hold_n,
  input wire logic core_rw,
  input wire logic core_strobe_n,
  input wire logic core_done0_n,
  input wire logic core_done0_oe,
  input wire logic core_done1_n,
  input wire logic core_done1_oe,
  // pad drive
  output logic [bsc_pkg::CELLS-1:0] cell_out,
  output logic [bsc_pkg::DATA_LOW_BITS-1:0] data_low_out,
  output logic addr_group_oe,
  output logic master_grant_n,
  output logic error_n,
  output logic bus_hold_n,
  output logic rw,
  output logic transfer_strobe_n,
  output logic dma_done0_n_o,
  output logic dma_done0_n_oe,
  output logic dma_done1_n_o,
  output logic dma_done1_n_oe
);
  import bsc_pkg::*;

  typedef struct packed {
    bsc_tap_e tap;
    logic tck_prev;
    logic [CELLS-1:0] chain;
    logic [CELLS-1:0] upd;
    logic tdo;
    logic tdo_oe;
    logic [DATA_LOW_BITS-1:0] data_low;
    logic group_oe;
    logic grant_n;
    logic err_n;
    logic hold_n;
    logic rw;
    logic strobe_n;
    logic d0_o;
    logic d0_oe;
    logic d1_o;
    logic d1_oe;
  } bsc_state_s;

  localparam int SYNC_W = 3 + PAD_INS + CELLS;

  bsc_state_s st;
  bsc_state_s next_st;
  logic scan_clear;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic [PAD_INS-1:0] pads_s;
  logic [CELLS-1:0] cap_s;
  logic tck_rise;
  logic tck_fall;

  function automatic bsc_tap_e tap_next(input bsc_tap_e s,
                                        input logic tms);
    unique case (s)
      TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: tap_next = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: tap_next = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
      default: tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  // order number to bit index
  function automatic int ix(input int pos);
    ix = pos - 1;
  endfunction : ix

  // either reset clears the scan side without a clock
  assign scan_clear = reset | ~test_rst_n;

  assign sync_in = {test_clk, test_mode_sel, test_data_in,
                    chip_reset_n, ext_master_req, mem_fault_in_n,
                    xfer_done_n, dma_done0_n_i, dma_done1_n_i,
                    pad_capture};

  bsc_sync #(
    .W(SYNC_W)
  ) u_sync (
    .clk(clk),
    .clear(scan_clear),
    .d(sync_in),
    .q(sync_out)
  );

  assign {tck_s, tms_s, tdi_s, pads_s, cap_s} = sync_out;
  assign tck_rise = tck_s & ~st.tck_prev;
  assign tck_fall = ~tck_s & st.tck_prev;

  always_comb begin
    logic [CELLS-1:0] cap;
    cap = cap_s;
    next_st = st;
    next_st.tck_prev = tck_s;
    // named pads take their fixed places
    cap[ix(POS_CHIP_RESET)] = pads_s[5];
    cap[ix(POS_EXT_REQ)] = pads_s[4];
    cap[ix(POS_MEM_FAULT)] = pads_s[3];
    cap[ix(POS_XFER_DONE)] = pads_s[2];
    cap[ix(POS_DONE0_IN)] = pads_s[1];
    cap[ix(POS_DONE1_IN)] = pads_s[0];
    // control cells have no pad: they recapture their own update value
    cap[ix(POS_GROUP_FLOAT)] = st.upd[ix(POS_GROUP_FLOAT)];
    cap[ix(POS_DONE0_DIR)] = st.upd[ix(POS_DONE0_DIR)];
    cap[ix(POS_DONE1_DIR)] = st.upd[ix(POS_DONE1_DIR)];
    if (tck_rise) begin
      next_st.tap = tap_next(st.tap, tms_s);
      if (st.tap == TAP_CAP_DR) begin
        next_st.chain = cap;
      end else if (st.tap == TAP_SH_DR) begin
        // cell 1 leaves first, tdi enters at cell 174
        next_st.chain = {tdi_s, st.chain[CELLS-1:1]};
      end
    end
    if (tck_fall) begin
      next_st.tdo = st.chain[ix(POS_COUNT_WRAP)];
      next_st.tdo_oe = (st.tap == TAP_SH_DR);
      // update only after the full shift has been walked out
      if (st.tap == TAP_UPD_DR) begin
        next_st.upd = st.chain;
      end
    end
    if (st.tap == TAP_RESET) begin
      next_st.tdo_oe = 1'b0;
    end
    // pad drive: low data bits always from update cells; others scan values while applying, core values otherwise
    for (int b = 0; b < DATA_LOW_BITS; b++) begin
      next_st.data_low[b] = st.upd[ix(POS_DATA0_OUT) - 2 * b];
    end
    if (scan_apply) begin
      next_st.group_oe = ~st.upd[ix(POS_GROUP_FLOAT)];
      next_st.grant_n = st.upd[ix(POS_GRANT)];
      next_st.err_n = st.upd[ix(POS_ERROR)];
      next_st.hold_n = st.upd[ix(POS_BUS_HOLD)];
      next_st.rw = st.upd[ix(POS_RW)];
      next_st.strobe_n = st.upd[ix(POS_STROBE)];
      next_st.d0_o = st.upd[ix(POS_DONE0_OUT)];
      next_st.d0_oe = ~st.upd[ix(POS_DONE0_DIR)];
      next_st.d1_o = st.upd[ix(POS_DONE1_OUT)];
      next_st.d1_oe = ~st.upd[ix(POS_DONE1_DIR)];
    end else begin
      next_st.group_oe = core_group_oe;
      next_st.grant_n = core_grant_n;
      next_st.err_n = core_error_n;
      next_st.hold_n = core_hold_n;
      next_st.rw = core_rw;
      next_st.strobe_n = core_strobe_n;
      next_st.d0_o = core_done0_n;
      next_st.d0_oe = core_done0_oe;
      next_st.d1_o = core_done1_n;
      next_st.d1_oe = core_done1_oe;
    end
  end

  always_ff @(posedge clk or posedge scan_clear) begin
    if (scan_clear) begin
      st.tap <= TAP_RESET;
      st.tck_prev <= 1'b0;
      st.chain <= '0;
      // control cells come up floating / as inputs
      st.upd <= '0 | ({{(CELLS-1){1'b0}}, 1'b1} << ix(POS_GROUP_FLOAT))
                   | ({{(CELLS-1){1'b0}}, 1'b1} << ix(POS_DONE0_DIR))
                   | ({{(CELLS-1){1'b0}}, 1'b1} << ix(POS_DONE1_DIR));
      st.tdo <= 1'b0;
      st.tdo_oe <= 1'b0;
      st.data_low <= '0;
      st.group_oe <= 1'b0;
      st.grant_n <= 1'b1;
      st.err_n <= 1'b1;
      st.hold_n <= 1'b1;
      st.rw <= 1'b1;
      st.strobe_n <= 1'b1;
      st.d0_o <= 1'b1;
      st.d0_oe <= 1'b0;
      st.d1_o <= 1'b1;
      st.d1_oe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign test_data_out = st.tdo;
  assign test_data_out_oe = st.tdo_oe;
  assign cell_out = st.upd;
  assign data_low_out = st.data_low;
  // grant, error and the other fixed pins have no float control
  assign addr_group_oe = st.group_oe;
  assign master_grant_n = st.grant_n;
  assign error_n = st.err_n;
  assign bus_hold_n = st.hold_n;
  assign rw = st.rw;
  assign transfer_strobe_n = st.strobe_n;
  assign dma_done0_n_o = st.d0_o;
  assign dma_done0_n_oe = st.d0_oe;
  assign dma_done1_n_o = st.d1_o;
  assign dma_done1_n_oe = st.d1_oe;

endmodule : bsc_chain

// ### verif/bsc_chain_checker.sv
`timescale 1ns/100ps
module bsc_chain_checker (
  // clock, resets and test port
  input wire logic clk,
  input wire logic reset,
  input wire logic test_clk,
  input wire logic test_rst_n,
  input wire logic test_data_out,
  input wire logic test_data_out_oe,
  // mux select and pad drive
  input wire logic scan_apply,
  input wire logic [bsc_pkg::CELLS-1:0] cell_out,
  input wire logic [bsc_pkg::DATA_LOW_BITS-1:0] data_low_out,
  input wire logic addr_group_oe,
  input wire logic master_grant_n,
  input wire logic transfer_strobe_n,
  input wire logic dma_done0_n_oe,
  input wire logic dma_done1_n_o
);
  import bsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset || !test_rst_n);
  // outputs lag the update cells by a clock, so both sides must be calm
  sequence s_calm;
    $past(test_rst_n) && !$past(reset) && $stable(cell_out);
  endsequence
  a_group_float:
    assert property ($past(scan_apply) ##0 s_calm |-> addr_group_oe == !cell_out[98])
    else $error("group enable not from float cell");
  a_done0_dir:
    assert property ($past(scan_apply) ##0 s_calm |-> dma_done0_n_oe == !cell_out[133])
    else $error("done0 direction not from its cell");
  a_done1_pin:
    assert property ($past(scan_apply) ##0 s_calm |-> dma_done1_n_o == cell_out[143])
    else $error("done1 drive not from its cell");
  a_grant_map:
    assert property ($past(scan_apply) ##0 s_calm |->
      master_grant_n == cell_out[99] && transfer_strobe_n == cell_out[104])
    else $error("grant or strobe from wrong cell");
  a_data_pairs:
    assert property (s_calm |-> data_low_out == {cell_out[83], cell_out[85],
      cell_out[87], cell_out[89], cell_out[91], cell_out[93]})
    else $error("data bits from wrong cells");
  a_test_reset:
    assert property (disable iff (reset) !test_rst_n |-> cell_out[98] &&
      cell_out[133] && !test_data_out_oe && !dma_done0_n_oe)
    else $error("test reset did not clear scan logic");
  a_tdo_low:
    assert property ($changed(test_data_out) |-> !test_clk)
    else $error("test data out moved while test clock high");
  a_update_low:
    assert property ($changed(cell_out) |-> !test_clk)
    else $error("update cells moved while test clock high");
  c_apply: cover property (scan_apply && addr_group_oe);
  c_float: cover property ($past(scan_apply) && !addr_group_oe);
  c_shift: cover property (test_data_out_oe);
endmodule : bsc_chain_checker

// ### verif/bsc_jtag_host.sv
`timescale 1ns/100ps
module bsc_jtag_host (
  // system clock
  input wire logic clk,
  // test port
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  import bsc_pkg::*;
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one test clock of 16 system clocks; tdo taken just before the rise
  // low and high phases of 8 each, so the period is 160 ns
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk);
    tck <= 1'h0;
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    o = tdo;
    tck <= 1'h1;
    repeat (7) @(posedge clk);
  endtask : step
  // idle, select, capture, 174 shifts, exit, update, idle
  task automatic scan_dr(input logic [CELLS-1:0] din,
                         output logic [CELLS-1:0] dout);
    logic o;
    step(1'h0, !tdi, o);
    step(1'h1, !tdi, o);
    step(1'h0, !tdi, o);
    step(1'h0, !tdi, o);
    for (int i = 0; i < CELLS; i++) begin
      step(i == CELLS - 1, din[i], dout[i]);
    end
    step(1'h1, !tdi, o);
    step(1'h0, !tdi, o);
    // clock stands low between frames
    @(posedge clk);
    tck <= 1'h0;
  endtask : scan_dr
endmodule : bsc_jtag_host

// ### verif/test_boundary_scan_chain.sv
`timescale 1ns/100ps
module test_boundary_scan_chain;
  import bsc_pkg::*;
  logic clk, reset, tck, tms, tdi, test_rst_n, tdo, tdo_oe, scan_apply;
  logic [CELLS-1:0] pads, cells, pat, got, exp_cap, prev;
  logic [5:0] named, data_low;
  logic [9:0] core;
  wire [9:0] pins;
  int err_total, cmp_count;
  bsc_chain bsc_chain_inst (
    .clk(clk), .reset(reset), .test_clk(tck), .test_mode_sel(tms),
    .test_data_in(tdi), .test_rst_n(test_rst_n), .test_data_out(tdo),
    .test_data_out_oe(tdo_oe), .pad_capture(pads),
    .chip_reset_n(named[0]), .ext_master_req(named[1]),
    .mem_fault_in_n(named[2]), .xfer_done_n(named[3]),
    .dma_done0_n_i(named[4]), .dma_done1_n_i(named[5]),
    .scan_apply(scan_apply), .core_group_oe(core[0]),
    .core_grant_n(core[1]), .core_error_n(core[2]), .core_hold_n(core[3]),
    .core_rw(core[4]), .core_strobe_n(core[5]), .core_done0_n(core[6]),
    .core_done0_oe(core[7]), .core_done1_n(core[8]),
    .core_done1_oe(core[9]), .cell_out(cells), .data_low_out(data_low),
    .addr_group_oe(pins[0]), .master_grant_n(pins[1]), .error_n(pins[2]),
    .bus_hold_n(pins[3]), .rw(pins[4]), .transfer_strobe_n(pins[5]),
    .dma_done0_n_o(pins[6]), .dma_done0_n_oe(pins[7]),
    .dma_done1_n_o(pins[8]), .dma_done1_n_oe(pins[9]));
  bsc_jtag_host bsc_jtag_host_inst (.clk(clk), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo));
  function automatic logic [CELLS-1:0] rnd();
    return CELLS'({$urandom(), $urandom(), $urandom(), $urandom(),
      $urandom(), $urandom()});
  endfunction : rnd
  // pad drive expected from update cells with scan_apply high
  function automatic logic [9:0] apply_model(input logic [CELLS-1:0] p);
    return {!p[140], p[143], !p[133], p[137], p[104], p[103], p[101],
      p[100], p[99], !p[98]};
  endfunction : apply_model
  task automatic check(input logic [CELLS-1:0] seen,
                       input logic [CELLS-1:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #1_000_000;
    err_total++;
    report_and_stop();
  end
  initial begin
    {reset, test_rst_n, scan_apply, pads, named, core} = '0;
    reset = 1'h1;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(32'hee7e));
    repeat (12) @(posedge clk);
    reset <= 1'h0;
    test_rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    for (int it = 0; it < 4; it++) begin
      if (it == 0 || it == 2) begin
        // at it 2 a mid-run test reset must bring back the reset update pattern; at it 0 no reset, power-up pattern checked
        test_rst_n <= (it == 0);
        repeat (2) @(posedge clk);
        prev = '0;
        prev[98] = 1'h1;
        prev[133] = 1'h1;
        prev[140] = 1'h1;
        check(cells, prev);
        test_rst_n <= 1'h1;
        repeat (4) @(posedge clk);
      end
      pat = rnd();
      pat[98] = it[0];
      pat[133] = it[1];
      pat[140] = !it[0];
      pads <= rnd();
      named <= 6'($urandom());
      core <= 10'($urandom());
      bsc_jtag_host_inst.scan_dr(pat, got);
      exp_cap = pads;
      exp_cap[97:94] = named[3:0];
      exp_cap[136] = named[4];
      exp_cap[142] = named[5];
      exp_cap[98] = prev[98];
      exp_cap[133] = prev[133];
      exp_cap[140] = prev[140];
      check(got, exp_cap);
      check(cells, pat);
      prev = pat;
      scan_apply <= 1'h1;
      repeat (3) @(posedge clk);
      check(CELLS'(pins), CELLS'(apply_model(pat)));
      for (int b = 0; b < 6; b++) begin
        check(CELLS'(data_low[b]), CELLS'(pat[93 - 2 * b]));
      end
      scan_apply <= 1'h0;
      repeat (3) @(posedge clk);
      check(CELLS'(pins), CELLS'(core));
    end
    report_and_stop();
  end
endmodule : test_boundary_scan_chain
bind bsc_chain bsc_chain_checker bsc_chain_checker_inst (.clk(clk),
  .reset(reset), .test_clk(test_clk), .test_rst_n(test_rst_n),
  .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe),
  .scan_apply(scan_apply), .cell_out(cell_out),
  .data_low_out(data_low_out), .addr_group_oe(addr_group_oe),
  .master_grant_n(master_grant_n), .transfer_strobe_n(transfer_strobe_n),
  .dma_done0_n_oe(dma_done0_n_oe), .dma_done1_n_o(dma_done1_n_o));
